// File: hdl/ssp_pkg.sv
// Register map, field positions and constants of the clocked serial port
package ssp_pkg;
   localparam int AW = 6;
   localparam logic [AW-1:0] OFS_BAUD_CTRL1 = 6'h00;
   localparam logic [AW-1:0] OFS_BAUD_CTRL2 = 6'h04;
   localparam logic [AW-1:0] OFS_INT_CTRL = 6'h08;
   localparam logic [AW-1:0] OFS_PERIPHERAL_IRQ_ENABLE_1 = 6'h0C;
   localparam logic [AW-1:0] OFS_PERIPHERAL_IRQ_FLAG_1 = 6'h10;
   localparam logic [AW-1:0] OFS_RX_BUF = 6'h14;
   localparam logic [AW-1:0] OFS_RX_STAT = 6'h18;
   localparam logic [AW-1:0] OFS_DIV_LO = 6'h1C;
   localparam logic [AW-1:0] OFS_DIV_HI = 6'h20;
   localparam logic [AW-1:0] OFS_TX_STAT = 6'h24;
   localparam logic [AW-1:0] OFS_TX_BUF = 6'h28;
   // baud_control_1 / baud_control_2
   localparam int POS_RX_IDLE = 6;
   localparam int POS_POLARITY = 4;
   localparam int POS_WIDE = 3;
   // interrupt_control
   localparam int POS_GLOBAL_EN = 7;
   localparam int POS_PERIPH_EN = 6;
   // peripheral_irq_enable_1 / peripheral_irq_flag_1
   localparam int POS_RX_IRQ = 5;
   localparam int POS_TX_IRQ = 4;
   // receive_status_control
   localparam int POS_PORT_EN = 7;
   localparam int POS_RX_NINE = 6;
   localparam int POS_SINGLE_RX = 5;
   localparam int POS_CONT_RX = 4;
   localparam int POS_OVERRUN = 1;
   localparam int POS_RX_BIT8 = 0;
   // transmit_status_control
   localparam int POS_MASTER = 7;
   localparam int POS_TX_NINE = 6;
   localparam int POS_TX_EN = 5;
   localparam int POS_CLOCKED = 4;
   localparam int POS_FAST = 2;
   localparam int POS_TX_EMPTY = 1;
   localparam int POS_TX_BIT8 = 0;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [3:0] BITS_NARROW = 4'h8;
   localparam logic [3:0] BITS_WIDE = 4'h9;
   localparam int SLOW_PRESCALE_SHIFT = 2;
   typedef enum logic {MS_IDLE = 1'b0, MS_ACTIVE = 1'b1} ssp_ms_t;
endpackage : ssp_pkg

// File: hdl/ssp_port.sv
// Clocked half-duplex serial port, master and slave, Avalon-MM registers
// Operation
// - Clocked mode; clock-source bit picks master or slave
// - Transmit when receive enables clear; slave checks continuous only
// - Port works only while enabled; clearing resets
// - Slave never drives the clock line
// - Two writes: first sent, second held, flag clear
// - First done: second moves in, flag sets
// - Transmit flag wakes with both enables; irq gated
// - Nine-bit transmit sends ninth bit as MSB
// - Sending needs transmit enable; buffer write starts
// - Slave uses continuous enable only, single ignored
// - Slave receives full word without core activity
// - Received word wakes when receive irq enabled
// - Receive flag on every word; irq needs enable
// - Ninth bit to status, low byte via FIFO
// - Overrun cleared by continuous enable or port clear
// - Master clock from divisor and speed options
// - Divisor is sixteen bits in two bytes with wide option, else low byte only
// - Polarity picks idle level and edges
// - One clock per bit, change on leading edge
// - Buffer waits while shifter busy, else moves
//
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
module ssp_port (
   input wire logic CLK,
   input wire logic RST_N,
   input wire logic CE,
   input wire logic [ssp_pkg::AW-1:0] AVS_ADDRESS,
   input wire logic AVS_READ,
   input wire logic AVS_WRITE,
   input wire logic [31:0] AVS_WRITEDATA,
   input wire logic [3:0] AVS_BYTEENABLE,
   output logic [31:0] AVS_READDATA,
   output logic AVS_WAITREQUEST,
   input wire logic DATA_LINE_IN,
   output logic DATA_LINE_OUT,
   output logic DATA_LINE_OE,
   input wire logic CLOCK_LINE_IN,
   output logic CLOCK_LINE_OUT,
   output logic CLOCK_LINE_OE,
   output logic WAKE,
   output logic IRQ
);
   import ssp_pkg::*;

   typedef struct packed {
      logic ack;
      logic [7:0] rdata;
      logic clock_idle_polarity;
      logic wide_baud_counter_option;
      logic high_speed_baud_option;
      logic global_irq_enable;
      logic peripheral_irq_enable;
      logic receive_irq_enable;
      logic transmit_irq_enable;
      logic port_enable;
      logic nine_bit_receive;
      logic single_receive_enable;
      logic continuous_receive_enable;
      logic clock_source_master;
      logic nine_bit_transmit;
      logic transmit_enable;
      logic clocked_mode;
      logic transmit_ninth_bit;
      logic [7:0] baud_divisor_low;
      logic [7:0] baud_divisor_high;
      logic [7:0] transmit_buffer;
      logic tx_full;
      logic tx_busy;
      logic [8:0] transmit_shift_register;
      logic [3:0] tx_left;
      logic data_out;
      logic [8:0] receive_shift_register;
      logic [3:0] rx_count;
      logic [1:0][8:0] rx_fifo;
      logic rd_ptr;
      logic [1:0] fifo_count;
      logic overrun_error_flag;
      ssp_ms_t ms;
      logic clk_active;
      logic [17:0] baud_count;
      logic dt_s1;
      logic dt_s2;
      logic ck_s1;
      logic ck_s2;
      logic ck_s3;
   } ssp_state_t;

   ssp_state_t s_r;
   ssp_state_t s_nxt;

   logic port_on;
   logic master;
   logic rx_mode;
   logic tx_on;
   logic load;
   logic tick;
   logic need_clk;
   logic lead;
   logic trail;
   logic req;
   logic wr;
   logic pop;
   logic rx_last;
   logic rx_done;
   logic rx_flag;
   logic tx_flag;
   logic [7:0] wd;
   logic [8:0] rx_new;
   logic [8:0] rx_word;
   logic [15:0] divisor;
   logic [17:0] reload;

   assign port_on = s_r.port_enable & s_r.clocked_mode;
   assign master = s_r.clock_source_master;
   // Slave listens on continuous enable alone
   assign rx_mode = master ?
      (s_r.single_receive_enable | s_r.continuous_receive_enable) :
      s_r.continuous_receive_enable;
   assign tx_on = port_on & s_r.transmit_enable & ~rx_mode;
   assign load = tx_on & ~s_r.tx_busy & s_r.tx_full;
   assign tick = s_r.baud_count == 18'h0;
   assign need_clk = (tx_on & s_r.tx_busy) |
      (port_on & rx_mode & ~s_r.overrun_error_flag);
   // Master edges come from its own generator, slave edges from the pin
   assign lead = port_on & (master ?
      (tick & s_r.ms == MS_IDLE & need_clk) :
      (s_r.ck_s3 == s_r.clock_idle_polarity &&
       s_r.ck_s2 != s_r.clock_idle_polarity));
   assign trail = port_on & (master ?
      (tick & s_r.ms == MS_ACTIVE) :
      (s_r.ck_s3 != s_r.clock_idle_polarity &&
       s_r.ck_s2 == s_r.clock_idle_polarity));
   assign divisor = s_r.wide_baud_counter_option ?
      {s_r.baud_divisor_high, s_r.baud_divisor_low} :
      {8'h00, s_r.baud_divisor_low};
   // Wraps correctly at the largest divisor
   assign reload = s_r.high_speed_baud_option ? {2'b00, divisor} :
      18'((({2'b00, divisor} + 18'h1) << SLOW_PRESCALE_SHIFT) - 18'h1);
   assign req = AVS_READ | AVS_WRITE;
   assign wr = AVS_WRITE & s_r.ack & AVS_BYTEENABLE[0];
   assign wd = AVS_WRITEDATA[7:0];
   assign pop = AVS_READ & s_r.ack & (AVS_ADDRESS == OFS_RX_BUF) &
      (s_r.fifo_count != 2'b00);
   assign rx_last = s_r.rx_count ==
      4'((s_r.nine_bit_receive ? BITS_WIDE : BITS_NARROW) - 4'h1);
   assign rx_done = trail & rx_mode & rx_last & ~s_r.overrun_error_flag;
   assign rx_new = {s_r.dt_s2, s_r.receive_shift_register[8:1]};
   assign rx_word = s_r.nine_bit_receive ? rx_new :
      {1'b0, rx_new[8:1]};
   assign rx_flag = s_r.fifo_count != 2'b00;
   assign tx_flag = ~s_r.tx_full;

   always_comb begin
      s_nxt = s_r;
      s_nxt.ck_s1 = CLOCK_LINE_IN;
      s_nxt.ck_s2 = s_r.ck_s1;
      s_nxt.ck_s3 = s_r.ck_s2;
      s_nxt.dt_s1 = DATA_LINE_IN;
      s_nxt.dt_s2 = s_r.dt_s1;
      s_nxt.ack = req & ~s_r.ack;
      // Read value captured one cycle ahead of the answer
      if (req & ~s_r.ack) begin
         unique case (AVS_ADDRESS)
            OFS_BAUD_CTRL1, OFS_BAUD_CTRL2: begin
               s_nxt.rdata = REG_RESET;
               s_nxt.rdata[POS_RX_IDLE] = s_r.rx_count == 4'h0;
               s_nxt.rdata[POS_POLARITY] = s_r.clock_idle_polarity;
               s_nxt.rdata[POS_WIDE] = s_r.wide_baud_counter_option;
            end
            OFS_INT_CTRL: begin
               s_nxt.rdata = REG_RESET;
               s_nxt.rdata[POS_GLOBAL_EN] = s_r.global_irq_enable;
               s_nxt.rdata[POS_PERIPH_EN] = s_r.peripheral_irq_enable;
            end
            OFS_PERIPHERAL_IRQ_ENABLE_1: begin
               s_nxt.rdata = REG_RESET;
               s_nxt.rdata[POS_RX_IRQ] = s_r.receive_irq_enable;
               s_nxt.rdata[POS_TX_IRQ] = s_r.transmit_irq_enable;
            end
            OFS_PERIPHERAL_IRQ_FLAG_1: begin
               s_nxt.rdata = REG_RESET;
               s_nxt.rdata[POS_RX_IRQ] = rx_flag;
               s_nxt.rdata[POS_TX_IRQ] = tx_flag;
            end
            OFS_RX_BUF: begin
               s_nxt.rdata = s_r.rx_fifo[s_r.rd_ptr][7:0];
            end
            OFS_RX_STAT: begin
               s_nxt.rdata = REG_RESET;
               s_nxt.rdata[POS_PORT_EN] = s_r.port_enable;
               s_nxt.rdata[POS_RX_NINE] = s_r.nine_bit_receive;
               s_nxt.rdata[POS_SINGLE_RX] = s_r.single_receive_enable;
               s_nxt.rdata[POS_CONT_RX] = s_r.continuous_receive_enable;
               s_nxt.rdata[POS_OVERRUN] = s_r.overrun_error_flag;
               s_nxt.rdata[POS_RX_BIT8] = s_r.rx_fifo[s_r.rd_ptr][8];
            end
            OFS_DIV_LO: begin
               s_nxt.rdata = s_r.baud_divisor_low;
            end
            OFS_DIV_HI: begin
               s_nxt.rdata = s_r.baud_divisor_high;
            end
            OFS_TX_STAT: begin
               s_nxt.rdata = REG_RESET;
               s_nxt.rdata[POS_MASTER] = s_r.clock_source_master;
               s_nxt.rdata[POS_TX_NINE] = s_r.nine_bit_transmit;
               s_nxt.rdata[POS_TX_EN] = s_r.transmit_enable;
               s_nxt.rdata[POS_CLOCKED] = s_r.clocked_mode;
               s_nxt.rdata[POS_FAST] = s_r.high_speed_baud_option;
               s_nxt.rdata[POS_TX_EMPTY] = ~s_r.tx_busy;
               s_nxt.rdata[POS_TX_BIT8] = s_r.transmit_ninth_bit;
            end
            default: begin
               s_nxt.rdata = REG_RESET;
            end
         endcase
      end
      // Buffer to shifter before the bus write, so a new write is kept
      if (load) begin
         s_nxt.transmit_shift_register =
            {s_r.transmit_ninth_bit, s_r.transmit_buffer};
         s_nxt.tx_busy = 1'b1;
         s_nxt.tx_full = 1'b0;
         s_nxt.tx_left = s_r.nine_bit_transmit ? BITS_WIDE : BITS_NARROW;
      end
      if (wr) begin
         unique case (AVS_ADDRESS)
            OFS_BAUD_CTRL1, OFS_BAUD_CTRL2: begin
               s_nxt.clock_idle_polarity = wd[POS_POLARITY];
               s_nxt.wide_baud_counter_option = wd[POS_WIDE];
            end
            OFS_INT_CTRL: begin
               s_nxt.global_irq_enable = wd[POS_GLOBAL_EN];
               s_nxt.peripheral_irq_enable = wd[POS_PERIPH_EN];
            end
            OFS_PERIPHERAL_IRQ_ENABLE_1: begin
               s_nxt.receive_irq_enable = wd[POS_RX_IRQ];
               s_nxt.transmit_irq_enable = wd[POS_TX_IRQ];
            end
            OFS_RX_STAT: begin
               s_nxt.port_enable = wd[POS_PORT_EN];
               s_nxt.nine_bit_receive = wd[POS_RX_NINE];
               s_nxt.single_receive_enable = wd[POS_SINGLE_RX];
               s_nxt.continuous_receive_enable = wd[POS_CONT_RX];
            end
            OFS_DIV_LO: begin
               s_nxt.baud_divisor_low = wd;
            end
            OFS_DIV_HI: begin
               s_nxt.baud_divisor_high = wd;
            end
            OFS_TX_STAT: begin
               s_nxt.clock_source_master = wd[POS_MASTER];
               s_nxt.nine_bit_transmit = wd[POS_TX_NINE];
               s_nxt.transmit_enable = wd[POS_TX_EN];
               s_nxt.clocked_mode = wd[POS_CLOCKED];
               s_nxt.high_speed_baud_option = wd[POS_FAST];
               s_nxt.transmit_ninth_bit = wd[POS_TX_BIT8];
            end
            OFS_TX_BUF: begin
               s_nxt.transmit_buffer = wd;
               s_nxt.tx_full = 1'b1;
            end
            default: begin
            end
         endcase
      end
      // Baud generator, one tick per half bit
      if (!port_on || !master || tick) begin
         s_nxt.baud_count = reload;
      end else begin
         s_nxt.baud_count = s_r.baud_count - 18'h1;
      end
      if (port_on && master && tick) begin
         unique case (s_r.ms)
            MS_IDLE: begin
               if (need_clk) begin
                  s_nxt.ms = MS_ACTIVE;
                  s_nxt.clk_active = 1'b1;
               end
            end
            MS_ACTIVE: begin
               s_nxt.ms = MS_IDLE;
               s_nxt.clk_active = 1'b0;
            end
         endcase
      end
      // Transmit: present on leading edge, advance on trailing edge
      if (tx_on && s_r.tx_busy && lead) begin
         s_nxt.data_out = s_r.transmit_shift_register[0];
      end
      if (tx_on && s_r.tx_busy && trail) begin
         s_nxt.transmit_shift_register =
            {1'b0, s_r.transmit_shift_register[8:1]};
         s_nxt.tx_left = s_r.tx_left - 4'h1;
         if (s_r.tx_left == 4'h1) begin
            s_nxt.tx_busy = 1'b0;
         end
      end
      if (pop) begin
         s_nxt.rd_ptr = ~s_r.rd_ptr;
         s_nxt.fifo_count = s_r.fifo_count - 2'b01;
      end
      // Receive runs on line edges only, no core activity needed
      if (trail && rx_mode && !s_r.overrun_error_flag) begin
         s_nxt.receive_shift_register = rx_new;
         s_nxt.rx_count = s_r.rx_count + 4'h1;
         if (rx_last) begin
            s_nxt.rx_count = 4'h0;
            if (s_nxt.fifo_count == 2'b10) begin
               s_nxt.overrun_error_flag = 1'b1;
            end else begin
               // Slot after the last held word; a same-cycle pop frees the head
               s_nxt.rx_fifo[s_r.rd_ptr ^ s_r.fifo_count[0]] = rx_word;
               s_nxt.fifo_count = s_nxt.fifo_count + 2'b01;
            end
            if (master && !s_r.continuous_receive_enable) begin
               s_nxt.single_receive_enable = 1'b0;
            end
         end
      end
      if (!s_r.continuous_receive_enable) begin
         s_nxt.overrun_error_flag = 1'b0;
         if (!s_r.single_receive_enable || !master) begin
            s_nxt.rx_count = 4'h0;
         end
      end
      // Port off resets everything but the settings
      if (!s_r.port_enable) begin
         s_nxt.overrun_error_flag = 1'b0;
         s_nxt.tx_busy = 1'b0;
         s_nxt.tx_full = 1'b0;
         s_nxt.tx_left = 4'h0;
         s_nxt.rx_count = 4'h0;
         s_nxt.fifo_count = 2'b00;
         s_nxt.rd_ptr = 1'b0;
         s_nxt.ms = MS_IDLE;
         s_nxt.clk_active = 1'b0;
         s_nxt.data_out = 1'b0;
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_N) begin
         s_r <= '0;
      end else if (CE) begin
         s_r <= s_nxt;
      end
   end

   assign AVS_WAITREQUEST = req & ~s_r.ack;
   assign AVS_READDATA = {24'h000000, s_r.rdata};
   assign DATA_LINE_OUT = s_r.data_out;
   // Data driven whenever transmit is on, in either role
   assign DATA_LINE_OE = tx_on;
   assign CLOCK_LINE_OE = port_on & master;
   assign CLOCK_LINE_OUT = s_r.clock_idle_polarity ^ s_r.clk_active;
   // Receive wake needs no peripheral gate; transmit wake does
   assign WAKE = (tx_flag & s_r.transmit_irq_enable &
      s_r.peripheral_irq_enable) |
      (rx_flag & s_r.receive_irq_enable);
   assign IRQ = WAKE & s_r.global_irq_enable;

   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (!RST_N);

   chk_slave_clock_pin: assert property (
      port_on && !master |-> !CLOCK_LINE_OE)
      else $error("slave drives clock line");
   chk_master_clock_pin: assert property (
      port_on && master |-> CLOCK_LINE_OE)
      else $error("master clock not driven");
   chk_tx_buffer_load: assert property (
      CE && load |=> s_r.tx_busy && s_r.tx_left ==
         ($past(s_r.nine_bit_transmit) ? BITS_WIDE : BITS_NARROW))
      else $error("buffer not moved to shifter");
   chk_ninth_bit_sent: assert property (
      CE && load && s_r.nine_bit_transmit |=>
         s_r.transmit_shift_register[8] == $past(s_r.transmit_ninth_bit))
      else $error("ninth bit not loaded");
   chk_clock_idle_level: assert property (
      s_r.ms == MS_IDLE |-> CLOCK_LINE_OUT == s_r.clock_idle_polarity)
      else $error("clock not at idle level");
   chk_overrun_clear: assert property (
      CE && !s_r.continuous_receive_enable |=> !s_r.overrun_error_flag)
      else $error("overrun not cleared");
   chk_port_reset: assert property (
      CE && !s_r.port_enable |=>
         s_r.fifo_count == 2'b00 && !s_r.tx_busy && !s_r.tx_full)
      else $error("port not reset");
   chk_rx_flag_set: assert property (
      CE && rx_done && s_r.fifo_count == 2'b00 |=> rx_flag)
      else $error("receive flag not set");
   chk_rx_wake: assert property (
      rx_flag && s_r.receive_irq_enable |-> WAKE)
      else $error("no wake on received word");
   chk_held_word_flag: assert property (
      CE && wr && AVS_ADDRESS == OFS_TX_BUF && s_r.tx_busy |=> !tx_flag)
      else $error("transmit flag set with word held");

   cov_nine_bit_send: cover property (load && s_r.nine_bit_transmit);
   cov_second_held: cover property (load ##1 s_r.tx_full);
   cov_word_received: cover property (rx_done);
   cov_overrun: cover property ($rose(s_r.overrun_error_flag));
endmodule : ssp_port

// File: tb/ssp_far.sv
// Far-end model: clock master for slave mode, line monitor for both modes
`timescale 1ns/1ps
module ssp_far (
   input wire logic clk,
   input wire logic pol,
   input wire logic dev_clk_out,
   input wire logic dev_clk_oe,
   input wire logic dev_data_out,
   input wire logic dev_data_oe,
   output logic clk_line,
   output logic data_line
);
   logic far_clk = 1'b0;
   logic far_dat = 1'b0;
   logic far_drv = 1'b0;
   logic last_dat = 1'b0;
   logic prev_clk = 1'b0;
   logic [17:0] mon_word = 18'h00000;
   int mon_bits = 0;
   int mon_act = 0;
   // Undriven data line toggles so a stale level never passes
   assign data_line = dev_data_oe ? dev_data_out :
                      far_drv ? far_dat : ~last_dat;
   assign clk_line = dev_clk_oe ? dev_clk_out : far_clk;
   always @(posedge clk) begin
      last_dat <= data_line;
      prev_clk <= clk_line;
      if (clk_line !== pol) begin
         mon_act <= mon_act + 1;
      end
      if (prev_clk !== pol && clk_line === pol) begin
         mon_word <= {data_line, mon_word[17:1]};
         mon_bits <= mon_bits + 1;
      end
   end
   task automatic mon_clr;
      @(negedge clk);
      mon_word = 18'h00000;
      mon_bits = 0;
      mon_act = 0;
   endtask : mon_clr
   // Clock stands still between frames; data held to next leading edge
   task automatic frame(input logic [8:0] w, input int n, input int h,
                        input logic drv);
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         far_clk <= ~pol;
         far_drv <= drv;
         far_dat <= w[i];
         repeat (h) @(posedge clk);
         far_clk <= pol;
         repeat (h - 1) @(posedge clk);
      end
      repeat (h) @(posedge clk);
      far_drv <= 1'b0;
   endtask : frame
endmodule : ssp_far

// File: tb/tb_top.sv
// Self-checking bench: register bus, master and slave transfers
`timescale 1ns/1ps
module tb_top;
   import ssp_pkg::*;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic [AW-1:0] adr = '0;
   logic rd = 1'b0;
   logic wr = 1'b0;
   logic [31:0] wdat = '0;
   logic [3:0] be = 4'hF;
   logic ce = 1'b1;
   logic [31:0] rdat;
   logic wreq, dout, doe, cout, coe, wake, irq, dline, cline;
   logic pol = 1'b0;
   logic [7:0] d, w0, w1;
   logic [8:0] wv;
   int fails = 0;
   int checked = 0;
   int seed;
   ssp_port u_ssp_port (.CLK(clk), .RST_N(rst_n), .CE(ce),
      .AVS_ADDRESS(adr), .AVS_READ(rd), .AVS_WRITE(wr),
      .AVS_WRITEDATA(wdat), .AVS_BYTEENABLE(be), .AVS_READDATA(rdat),
      .AVS_WAITREQUEST(wreq), .DATA_LINE_IN(dline), .DATA_LINE_OUT(dout),
      .DATA_LINE_OE(doe), .CLOCK_LINE_IN(cline), .CLOCK_LINE_OUT(cout),
      .CLOCK_LINE_OE(coe), .WAKE(wake), .IRQ(irq));
   ssp_far u_ssp_far (.clk(clk), .pol(pol), .dev_clk_out(cout),
      .dev_clk_oe(coe), .dev_data_out(dout), .dev_data_oe(doe),
      .clk_line(cline), .data_line(dline));
   initial begin
      forever #5 clk = ~clk;
   end
   function automatic logic [7:0] bm(input int p);
      return 8'h01 << p;
   endfunction : bm
   task automatic check(input logic [31:0] s, input logic [31:0] e);
      checked++;
      if (s !== e) begin
         fails++;
         $display("MISMATCH t=%0t seen %0h exp %0h", $time, s, e);
      end
   endtask : check
   // Request held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic [AW-1:0] a, input logic w,
                      input logic [7:0] v, output logic [7:0] q);
      @(posedge clk);
      adr <= a;
      rd <= ~w;
      wr <= w;
      wdat <= {24'h000000, v};
      @(posedge clk);
      while (wreq !== 1'b0) @(posedge clk);
      q = rdat[7:0];
      rd <= 1'b0;
      wr <= 1'b0;
      // Let the write settle before callers look at outputs
      @(posedge clk);
   endtask : bus
   task automatic wr8(input logic [AW-1:0] a, input logic [7:0] v);
      logic [7:0] q;
      bus(a, 1'b1, v, q);
   endtask : wr8
   task automatic rd8(input logic [AW-1:0] a, output logic [7:0] q);
      bus(a, 1'b0, 8'h00, q);
   endtask : rd8
   task final_report;
      $display("checks %0d mismatches %0d", checked, fails);
      if (fails == 0 && checked > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask : final_report
   // x selects nine bits, wide divisor and fast prescale together
   task automatic master_tx(input logic p, input logic x);
      int n, h, nb;
      logic b8;
      n = $urandom_range(3, 1);
      h = x ? 257 + n : 4 * (n + 1);
      nb = x ? 9 : 8;
      b8 = 1'($urandom);
      w0 = 8'($urandom);
      w1 = 8'($urandom);
      pol <= p;
      wr8(OFS_BAUD_CTRL1, (p ? bm(POS_POLARITY) : 8'h00) |
                          (x ? bm(POS_WIDE) : 8'h00));
      wr8(OFS_DIV_LO, 8'(n));
      wr8(OFS_DIV_HI, {7'h00, x});
      wr8(OFS_RX_STAT, bm(POS_PORT_EN));
      wr8(OFS_TX_STAT, bm(POS_MASTER) | bm(POS_TX_EN) | bm(POS_CLOCKED) |
          (x ? bm(POS_FAST) | bm(POS_TX_NINE) : 8'h00) | {7'h00, b8});
      repeat (4) @(posedge clk);
      check(cline, p);
      check(coe, 1'b1);
      u_ssp_far.mon_clr();
      wr8(OFS_TX_BUF, w0);
      wr8(OFS_TX_BUF, w1);
      rd8(OFS_PERIPHERAL_IRQ_FLAG_1, d);
      check(d[POS_TX_IRQ], 1'b0);
      check(wake, 1'b0);
      for (int i = 0; i < 20000 && u_ssp_far.mon_bits < 2 * nb; i++)
         @(posedge clk);
      repeat (4) @(posedge clk);
      check(u_ssp_far.mon_bits, 2 * nb);
      check(u_ssp_far.mon_act, 2 * nb * h);
      check(u_ssp_far.mon_word >> (18 - 2 * nb),
            x ? {b8, w1, b8, w0} : {w1, w0});
      rd8(OFS_PERIPHERAL_IRQ_FLAG_1, d);
      check(d[POS_TX_IRQ], 1'b1);
      check(wake, 1'b1);
      check(irq, 1'b0);
   endtask : master_tx
   initial begin
      repeat (50000) @(posedge clk);
      fails++;
      final_report();
   end
   initial begin
      seed = $urandom(32'hBA141BBB);
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      rd8(OFS_PERIPHERAL_IRQ_FLAG_1, d);
      check(d, bm(POS_TX_IRQ));
      rd8(OFS_RX_STAT, d);
      check(d, REG_RESET);
      rd8(6'h3C, d);
      check(d, 8'h00);
      be <= 4'h0;
      wr8(OFS_DIV_LO, 8'h5A);
      be <= 4'hF;
      rd8(OFS_DIV_LO, d);
      check(d, REG_RESET);
      // Clock enable low stretches the wait, then the write lands
      ce <= 1'b0;
      fork
         wr8(OFS_DIV_LO, 8'h3C);
         begin
            repeat (6) @(posedge clk);
            ce <= 1'b1;
         end
      join
      rd8(OFS_DIV_LO, d);
      check(d, 8'h3C);
      wr8(OFS_PERIPHERAL_IRQ_ENABLE_1, bm(POS_TX_IRQ));
      wr8(OFS_INT_CTRL, bm(POS_PERIPH_EN));
      master_tx(1'b0, 1'b0);
      master_tx(1'b1, 1'b1);
      wr8(OFS_INT_CTRL, bm(POS_PERIPH_EN) | bm(POS_GLOBAL_EN));
      check(irq, 1'b1);
      // Transmit disabled: buffer write must not start a frame
      wr8(OFS_TX_STAT, bm(POS_MASTER) | bm(POS_CLOCKED));
      u_ssp_far.mon_clr();
      wr8(OFS_TX_BUF, 8'hA5);
      repeat (100) @(posedge clk);
      check(u_ssp_far.mon_bits, 0);
      check(doe, 1'b0);
      // Slave reception, single enable set too and ignored
      wr8(OFS_RX_STAT, REG_RESET);
      pol <= 1'b0;
      wr8(OFS_BAUD_CTRL1, REG_RESET);
      wr8(OFS_TX_STAT, bm(POS_CLOCKED));
      wr8(OFS_PERIPHERAL_IRQ_ENABLE_1, bm(POS_RX_IRQ));
      wr8(OFS_RX_STAT, bm(POS_PORT_EN) | bm(POS_RX_NINE) |
                       bm(POS_SINGLE_RX) | bm(POS_CONT_RX));
      check(coe, 1'b0);
      check(doe, 1'b0);
      for (int k = 0; k < 3; k++) begin
         wv = 9'($urandom);
         u_ssp_far.frame(wv, 9, 8, 1'b1);
         repeat (6) @(posedge clk);
         check(wake, 1'b1);
         rd8(OFS_RX_STAT, d);
         check(d[POS_RX_BIT8], wv[8]);
         rd8(OFS_RX_BUF, d);
         check(d, wv[7:0]);
      end
      rd8(OFS_PERIPHERAL_IRQ_FLAG_1, d);
      check(d[POS_RX_IRQ], 1'b0);
      for (int k = 0; k < 3; k++) u_ssp_far.frame(9'h0C3, 9, 8, 1'b1);
      rd8(OFS_RX_STAT, d);
      check(d[POS_OVERRUN], 1'b1);
      wr8(OFS_RX_STAT, bm(POS_PORT_EN) | bm(POS_RX_NINE));
      rd8(OFS_RX_STAT, d);
      check(d[POS_OVERRUN], 1'b0);
      wr8(OFS_RX_STAT, REG_RESET);
      rd8(OFS_PERIPHERAL_IRQ_FLAG_1, d);
      check(d[POS_RX_IRQ], 1'b0);
      // Slave transmit clocked by the far end
      wr8(OFS_RX_STAT, bm(POS_PORT_EN));
      wr8(OFS_TX_STAT, bm(POS_CLOCKED) | bm(POS_TX_EN));
      w0 = 8'($urandom);
      wr8(OFS_TX_BUF, w0);
      u_ssp_far.mon_clr();
      u_ssp_far.frame(9'h000, 8, 8, 1'b0);
      repeat (4) @(posedge clk);
      check(u_ssp_far.mon_word[17:10], w0);
      check(coe, 1'b0);
      final_report();
   end
endmodule : tb_top
